// ---- dtc_decoder.sv ----
// Drive terminal command decoder: turns digital input terminals into control actions.
// Assumes terminals and core inputs are synchronous to clock; AHB-Lite slave, one master.
//
// Functional notes
// - Coast stop command cuts drive output at once, without any alarm.
// - Alarm clear drops fault output while held; its release clears alarm and hold.
// - External trip going inactive cuts output, shows trip alarm, asserts fault output.
// - External trip stays latched until an alarm reset, even after input returns.
// - Frequency from primary setting when switch inactive, secondary when active.
// - Unassigned frequency switch selects the primary setting.
// - DC brake command brakes while active, ignoring duration, even when stopped.
// - Keypad edits blocked without permit; protect setting 0 all, 1 own only.
// - Unassigned keypad write permit counts as always active.
// - Inverse select acts only on analog primary frequency source.
// - Effective sense is reverse sense setting XOR inverse select; true is inverse.
// - Active interlock input signals a momentary power failure occurred.
// - Active comm priority favours link commands; unassigned behaves as active.
// - Monitor-only inputs readable over the link only, never affect operation.
// - At each start, start-search select decides whether to catch a spinning motor.
// - Forced stop decelerates to rest, then enters the forced-stop alarm.
// - Local select moves run and frequency sources to the keypad.
// - Dew protect drives heating DC into a halted motor.
// - Codes 87, 88, 89 select run source and alternate forward and reverse.
// - Link off: run from setting, or from alternate run inputs when switched.
// - Alternate forward runs forward, reverse runs reverse; release decelerates.
// - Trip and forced stop are fail-safe: 9 or 30 trigger on off level.
`timescale 1ns/1ps

module dtc_decoder
  import dtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_TERM-1:0] termIn,
  input wire logic motorHalted,
  input wire logic startReq,
  input wire logic keypadRunFwd,
  input wire logic keypadRunRev,
  input wire logic commRunFwd,
  input wire logic commRunRev,
  input wire logic extRunFwd,
  input wire logic extRunRev,
  output logic driveOn,
  output logic faultOutput,
  output logic [1:0] alarmCode,
  output logic [1:0] freqSel,
  output logic inverseOn,
  output logic dcBrake,
  output logic outageFlag,
  output logic commPriority,
  output logic dewHeat,
  output logic runFwd,
  output logic runRev,
  output logic forcedDecel,
  output logic editAll,
  output logic editOwnOnly,
  output logic startSearch
);

  typedef struct packed {
    logic [NUM_TERM-1:0] termMeta;
    logic [NUM_TERM-1:0] termSync;
    logic [NUM_TERM-1:0][CODE_W-1:0] assignCode;
    logic [CFG_W-1:0] cfg;
    logic wrPend;
    logic [5:0] wrIdx;
    logic tripHeld;
    dtc_alarm_e alarm;
    logic clearPrev;
    logic searchSel;
    logic driveOn;
    logic fault;
    logic [1:0] freqSel;
    logic inverse;
    logic dcBrake;
    logic outage;
    logic commPri;
    logic dew;
    logic runFwd;
    logic runRev;
    logic forced;
    logic editAll;
    logic editOwn;
    logic [NUM_TERM-1:0] monitor;
    logic [31:0] rdata;
  } dtc_state_s;

  localparam dtc_state_s STATE_RESET = '0;

  dtc_state_s state_reg;
  dtc_state_s state_next;

  // Level of a command: onCode means active on high input, offCode on low input
  function automatic logic cmdLevel(input logic [NUM_TERM-1:0][CODE_W-1:0] a,
                                    input logic [NUM_TERM-1:0] lv,
                                    input logic [CODE_W-1:0] onCode,
                                    input logic [CODE_W-1:0] offCode);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (a[i] == onCode) begin
        r = r | lv[i];
      end else if (a[i] == offCode) begin
        r = r | ~lv[i];
      end
    end
    return r;
  endfunction

  function automatic logic cmdAssigned(input logic [NUM_TERM-1:0][CODE_W-1:0] a,
                                       input logic [CODE_W-1:0] onCode,
                                       input logic [CODE_W-1:0] offCode);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      r = r | (a[i] == onCode) | (a[i] == offCode);
    end
    return r;
  endfunction

  logic busTake;
  logic coastAct, clearAct, tripAct, freqSwAct, brakeAct, permitAct, invAct;
  logic outageAct, commAct, searchAct, stopAct, localAct, dewAct;
  logic runSwAct, fwdAltAct, revAltAct;
  logic [31:0] statusWord;

  assign busTake = hsel & hready & htrans[1];

  always_comb begin
    dtc_state_s n;
    logic [NUM_TERM-1:0][CODE_W-1:0] a;
    logic [NUM_TERM-1:0] lv;
    logic permit;
    logic primaryInUse;
    n = state_reg;
    a = state_reg.assignCode;
    lv = state_reg.termSync;
    permit = 1'b0;
    primaryInUse = 1'b0;

    // Commands act only on the second-stage sampled level
    n.termMeta = termIn;
    n.termSync = state_reg.termMeta;

    coastAct = cmdLevel(a, lv, CODE_COAST, CODE_COAST_N);
    clearAct = cmdLevel(a, lv, CODE_CLEAR, CODE_CLEAR_N);
    tripAct = cmdLevel(a, lv, CODE_TRIP_ON, CODE_TRIP_OFF);
    freqSwAct = cmdLevel(a, lv, CODE_FREQ_SW, CODE_FREQ_SW_N);
    brakeAct = cmdLevel(a, lv, CODE_DCBRAKE, CODE_DCBRAKE);
    permitAct = cmdLevel(a, lv, CODE_PERMIT, CODE_PERMIT_N);
    invAct = cmdLevel(a, lv, CODE_INVERSE, CODE_INVERSE_N);
    outageAct = cmdLevel(a, lv, CODE_OUTAGE, CODE_OUTAGE_N);
    commAct = cmdLevel(a, lv, CODE_COMM, CODE_COMM_N);
    searchAct = cmdLevel(a, lv, CODE_SEARCH, CODE_SEARCH_N);
    stopAct = cmdLevel(a, lv, CODE_STOP_ON, CODE_STOP_OFF);
    localAct = cmdLevel(a, lv, CODE_LOCAL, CODE_LOCAL_N);
    dewAct = cmdLevel(a, lv, CODE_DEW, CODE_DEW);
    runSwAct = cmdLevel(a, lv, CODE_RUN_SW, CODE_RUN_SW_N);
    fwdAltAct = cmdLevel(a, lv, CODE_FWD_ALT, CODE_FWD_ALT);
    revAltAct = cmdLevel(a, lv, CODE_REV_ALT, CODE_REV_ALT);

    // Trip latch; a new trip in the clear's release cycle wins
    n.clearPrev = clearAct;
    if (tripAct) begin
      n.tripHeld = 1'b1;
    end else if (state_reg.clearPrev && !clearAct) begin
      n.tripHeld = 1'b0;
    end

    case (state_reg.alarm)
      ALARM_NONE: begin
        if (tripAct) begin
          n.alarm = ALARM_EXT_TRIP;
        end else if (stopAct && motorHalted) begin
          n.alarm = ALARM_FORCED_STOP;
        end
      end
      ALARM_EXT_TRIP, ALARM_FORCED_STOP: begin
        if (state_reg.clearPrev && !clearAct && !tripAct && !stopAct) begin
          n.alarm = ALARM_NONE;
        end
      end
      default: n.alarm = ALARM_NONE;
    endcase

    // Coast needs no alarm; a trip cuts output on the same edge as the alarm registers
    n.driveOn = !coastAct && !tripAct && !state_reg.tripHeld &&
                (n.alarm == ALARM_NONE);
    n.fault = (n.alarm != ALARM_NONE) && !clearAct;
    n.forced = stopAct && (n.alarm == ALARM_NONE);

    if (localAct) begin
      n.freqSel = FSEL_KEYPAD;
    end else if (freqSwAct) begin
      n.freqSel = FSEL_SECONDARY;
    end else begin
      n.freqSel = FSEL_PRIMARY;
    end

    // Sense only touches the analog primary path
    primaryInUse = (n.freqSel == FSEL_PRIMARY) && state_reg.cfg[CFG_PRI_ANALOG];
    n.inverse = primaryInUse &&
                (state_reg.cfg[CFG_REV_SENSE] ^ invAct);

    n.dcBrake = brakeAct;
    n.dew = dewAct && motorHalted;
    n.outage = outageAct;

    n.commPri = cmdAssigned(a, CODE_COMM, CODE_COMM_N) ? commAct : 1'b1;

    permit = cmdAssigned(a, CODE_PERMIT, CODE_PERMIT_N) ? permitAct : 1'b1;
    n.editAll = permit && !state_reg.cfg[CFG_PROTECT];
    n.editOwn = permit && state_reg.cfg[CFG_PROTECT];

    if (startReq) begin
      n.searchSel = searchAct;
    end

    // Run source priority: local keypad, then link, then switched alternate terminals, then run source setting (external or keypad)
    if (localAct) begin
      n.runFwd = keypadRunFwd && !keypadRunRev;
      n.runRev = keypadRunRev && !keypadRunFwd;
    end else if (state_reg.cfg[CFG_COMM_EN] && n.commPri) begin
      n.runFwd = commRunFwd && !commRunRev;
      n.runRev = commRunRev && !commRunFwd;
    end else if (runSwAct) begin
      n.runFwd = fwdAltAct && !revAltAct;
      n.runRev = revAltAct && !fwdAltAct;
    end else if (state_reg.cfg[CFG_RUN_SRC]) begin
      n.runFwd = extRunFwd && !extRunRev;
      n.runRev = extRunRev && !extRunFwd;
    end else begin
      n.runFwd = keypadRunFwd && !keypadRunRev;
      n.runRev = keypadRunRev && !keypadRunFwd;
    end
    if (!n.driveOn || stopAct) begin
      n.runFwd = 1'b0;
      n.runRev = 1'b0;
    end

    // Monitor bits reach only the register file
    for (int i = 0; i < NUM_TERM; i++) begin
      n.monitor[i] = ((a[i] == CODE_MONITOR) & lv[i]) |
                     ((a[i] == CODE_MONITOR_N) & ~lv[i]);
    end

    statusWord = '0;
    statusWord[ST_DRIVE_ON] = state_reg.driveOn;
    statusWord[ST_FAULT] = state_reg.fault;
    statusWord[ST_ALARM +: 2] = state_reg.alarm;
    statusWord[ST_FREQ_SEL +: 2] = state_reg.freqSel;
    statusWord[ST_INVERSE] = state_reg.inverse;
    statusWord[ST_OUTAGE] = state_reg.outage;
    statusWord[ST_COMM_PRI] = state_reg.commPri;
    statusWord[ST_DC_BRAKE] = state_reg.dcBrake;
    statusWord[ST_DEW] = state_reg.dew;
    statusWord[ST_RUN_FWD] = state_reg.runFwd;
    statusWord[ST_RUN_REV] = state_reg.runRev;
    statusWord[ST_FORCED] = state_reg.forced;
    statusWord[ST_EDIT_ALL] = state_reg.editAll;
    statusWord[ST_EDIT_OWN] = state_reg.editOwn;
    statusWord[ST_SEARCH] = state_reg.searchSel;

    // Bus: writes land in the data phase, read data is staged at address phase
    n.wrPend = busTake && hwrite;
    if (busTake) begin
      n.wrIdx = haddr[7:2];
    end
    if (state_reg.wrPend) begin
      if (state_reg.wrIdx < 6'(NUM_TERM)) begin
        n.assignCode[state_reg.wrIdx[2:0]] = hwdata[CODE_W-1:0];
      end else if (state_reg.wrIdx == OFF_CONFIG[7:2]) begin
        n.cfg = hwdata[CFG_W-1:0];
      end
    end
    n.rdata = '0;
    if (busTake && !hwrite) begin
      if (haddr[7:2] < 6'(NUM_TERM) && haddr[31:8] == 24'h000000) begin
        n.rdata = {21'h000000, a[haddr[4:2]]};
      end else if (haddr[31:0] == {24'h000000, OFF_CONFIG}) begin
        n.rdata = {27'h0000000, state_reg.cfg};
      end else if (haddr[31:0] == {24'h000000, OFF_STATUS}) begin
        n.rdata = statusWord;
      end else if (haddr[31:0] == {24'h000000, OFF_MONITOR}) begin
        n.rdata = {27'h0000000, state_reg.monitor};
      end
    end
    if (n.wrPend && haddr[31:8] != 24'h000000) begin
      n.wrPend = 1'b0;
    end

    state_next = n;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign driveOn = state_reg.driveOn;
  assign faultOutput = state_reg.fault;
  assign alarmCode = state_reg.alarm;
  assign freqSel = state_reg.freqSel;
  assign inverseOn = state_reg.inverse;
  assign dcBrake = state_reg.dcBrake;
  assign outageFlag = state_reg.outage;
  assign commPriority = state_reg.commPri;
  assign dewHeat = state_reg.dew;
  assign runFwd = state_reg.runFwd;
  assign runRev = state_reg.runRev;
  assign forcedDecel = state_reg.forced;
  assign editAll = state_reg.editAll;
  assign editOwnOnly = state_reg.editOwn;
  assign startSearch = state_reg.searchSel;

  a_coast_cuts: assert property (@(posedge clock) disable iff (!rst_n)
    coastAct && !tripAct && !stopAct && state_reg.alarm == ALARM_NONE
      |=> !driveOn && alarmCode == ALARM_NONE && !faultOutput)
    else $error("coast did not cut output");
  a_clear_fault: assert property (@(posedge clock) disable iff (!rst_n)
    clearAct |=> !faultOutput)
    else $error("fault output high during alarm clear");
  a_trip_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    tripAct |=> !driveOn && faultOutput == !$past(clearAct) && alarmCode != ALARM_NONE)
    else $error("trip did not raise alarm");
  a_trip_held: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg.tripHeld && !(state_reg.clearPrev && !clearAct) |=> state_reg.tripHeld)
    else $error("trip latch dropped without reset");
  a_freq_select: assert property (@(posedge clock) disable iff (!rst_n)
    !localAct |=> freqSel == ($past(freqSwAct) ? FSEL_SECONDARY : FSEL_PRIMARY))
    else $error("wrong frequency source");
  a_brake_follow: assert property (@(posedge clock) disable iff (!rst_n)
    brakeAct [*3] |=> dcBrake)
    else $error("DC brake not held");
  a_edit_block: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdAssigned(state_reg.assignCode, CODE_PERMIT, CODE_PERMIT_N) && !permitAct)
      |=> !editAll && !editOwnOnly)
    else $error("keypad edit not blocked");
  a_sense_xor: assert property (@(posedge clock) disable iff (!rst_n)
    (freqSel == FSEL_PRIMARY && state_reg.cfg[CFG_PRI_ANALOG] && !localAct && !freqSwAct)
      |=> inverseOn == ($past(state_reg.cfg[CFG_REV_SENSE]) ^ $past(invAct)))
    else $error("control sense wrong");
  a_dew_halted: assert property (@(posedge clock) disable iff (!rst_n)
    dewHeat |-> $past(motorHalted))
    else $error("dew heating while motor turns");
  a_sync_delay: assert property (@(posedge clock) disable iff (!rst_n)
    ##2 state_reg.termSync == $past(termIn, 2))
    else $error("terminal sampling delay wrong");

endmodule

// ---- dtc_pkg.sv ----
// Package for the drive terminal command decoder.
// Assumes a single 125 MHz control clock and an AHB-Lite register bus.
package dtc_pkg;

  localparam int NUM_TERM = 5;
  localparam int CODE_W = 11;

  // Byte offsets of the register file
  localparam logic [7:0] OFF_ASSIGN0 = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MONITOR = 8'h1c;

  // Configuration fields
  localparam int CFG_REV_SENSE = 0;
  localparam int CFG_PROTECT = 1;
  localparam int CFG_RUN_SRC = 2;
  localparam int CFG_COMM_EN = 3;
  localparam int CFG_PRI_ANALOG = 4;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  localparam logic [CODE_W-1:0] ASSIGN_RESET = 11'h000;

  // Status fields
  localparam int ST_DRIVE_ON = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_FREQ_SEL = 4;
  localparam int ST_INVERSE = 6;
  localparam int ST_OUTAGE = 7;
  localparam int ST_COMM_PRI = 8;
  localparam int ST_DC_BRAKE = 9;
  localparam int ST_DEW = 10;
  localparam int ST_RUN_FWD = 11;
  localparam int ST_RUN_REV = 12;
  localparam int ST_FORCED = 13;
  localparam int ST_EDIT_ALL = 14;
  localparam int ST_EDIT_OWN = 15;
  localparam int ST_SEARCH = 16;

  // Assignment codes: active-on value, then active-off value where the command has one
  localparam logic [CODE_W-1:0] CODE_COAST = 11'h007;
  localparam logic [CODE_W-1:0] CODE_COAST_N = 11'h3ef;
  localparam logic [CODE_W-1:0] CODE_CLEAR = 11'h008;
  localparam logic [CODE_W-1:0] CODE_CLEAR_N = 11'h3f0;
  localparam logic [CODE_W-1:0] CODE_TRIP_ON = 11'h3f1;
  localparam logic [CODE_W-1:0] CODE_TRIP_OFF = 11'h009;
  localparam logic [CODE_W-1:0] CODE_FREQ_SW = 11'h00b;
  localparam logic [CODE_W-1:0] CODE_FREQ_SW_N = 11'h3f3;
  localparam logic [CODE_W-1:0] CODE_DCBRAKE = 11'h00d;
  localparam logic [CODE_W-1:0] CODE_PERMIT = 11'h013;
  localparam logic [CODE_W-1:0] CODE_PERMIT_N = 11'h3fb;
  localparam logic [CODE_W-1:0] CODE_INVERSE = 11'h015;
  localparam logic [CODE_W-1:0] CODE_INVERSE_N = 11'h3fd;
  localparam logic [CODE_W-1:0] CODE_OUTAGE = 11'h016;
  localparam logic [CODE_W-1:0] CODE_OUTAGE_N = 11'h3fe;
  localparam logic [CODE_W-1:0] CODE_COMM = 11'h018;
  localparam logic [CODE_W-1:0] CODE_COMM_N = 11'h400;
  localparam logic [CODE_W-1:0] CODE_MONITOR = 11'h019;
  localparam logic [CODE_W-1:0] CODE_MONITOR_N = 11'h401;
  localparam logic [CODE_W-1:0] CODE_SEARCH = 11'h01a;
  localparam logic [CODE_W-1:0] CODE_SEARCH_N = 11'h402;
  localparam logic [CODE_W-1:0] CODE_STOP_ON = 11'h406;
  localparam logic [CODE_W-1:0] CODE_STOP_OFF = 11'h01e;
  localparam logic [CODE_W-1:0] CODE_LOCAL = 11'h023;
  localparam logic [CODE_W-1:0] CODE_LOCAL_N = 11'h40b;
  localparam logic [CODE_W-1:0] CODE_DEW = 11'h027;
  localparam logic [CODE_W-1:0] CODE_RUN_SW = 11'h057;
  localparam logic [CODE_W-1:0] CODE_RUN_SW_N = 11'h43f;
  localparam logic [CODE_W-1:0] CODE_FWD_ALT = 11'h058;
  localparam logic [CODE_W-1:0] CODE_REV_ALT = 11'h059;

  // Frequency source select values
  localparam logic [1:0] FSEL_PRIMARY = 2'h0;
  localparam logic [1:0] FSEL_SECONDARY = 2'h1;
  localparam logic [1:0] FSEL_KEYPAD = 2'h2;

  typedef enum logic [1:0] {ALARM_NONE, ALARM_EXT_TRIP, ALARM_FORCED_STOP} dtc_alarm_e;

endpackage

// ---- dtc_term_model.sv ----
// External controller model driving the digital input terminals.
// Assumes the bench supplies wanted levels just after a rising clock edge.
`timescale 1ns/1ps

module dtc_term_model
  import dtc_pkg::*;
#(
  // 10 ms at 125 MHz; the bench shortens it to keep the run brief
  parameter int CLEAR_HOLD = 1250000
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [NUM_TERM-1:0] want,
  input wire logic [NUM_TERM-1:0] clearSel,
  output logic [NUM_TERM-1:0] termIn
);
  int holdCnt;
  logic [NUM_TERM-1:0] keepOn;

  // A clear terminal is never released early, whatever the bench asks
  assign keepOn = (holdCnt != 0) ? (clearSel & termIn) : '0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      termIn <= want;
      holdCnt <= 0;
    end else begin
      termIn <= want | keepOn;
      if (|(clearSel & want & ~termIn)) begin
        holdCnt <= CLEAR_HOLD;
      end else if (holdCnt != 0) begin
        holdCnt <= holdCnt - 1;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the terminal command decoder.
// Assumes one 125 MHz clock; terminal 1 carries alarm clear throughout.
`timescale 1ns/1ps

module tb_top;
  import dtc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, driveOn, faultOutput, inverseOn, dcBrake, outageFlag;
  logic commPriority, dewHeat, runFwd, runRev, forcedDecel, editAll, editOwnOnly;
  logic startSearch;
  logic [31:0] hrdata;
  logic [1:0] alarmCode, freqSel;
  logic [NUM_TERM-1:0] termIn;
  logic [NUM_TERM-1:0] termWant = '0;
  logic [NUM_TERM-1:0] clearSel = 5'h02;
  logic motorHalted = 1'b0;
  logic startReq = 1'b0;
  logic keypadRunFwd = 1'b0;
  logic extRunFwd = 1'b0;
  logic commRunRev = 1'b0;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  dtc_term_model #(.CLEAR_HOLD(20)) partner (.clock(clock), .rst_n(rst_n), .want(termWant),
    .clearSel(clearSel), .termIn(termIn));

  dtc_decoder uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .termIn(termIn),
    .motorHalted(motorHalted), .startReq(startReq), .keypadRunFwd(keypadRunFwd),
    .keypadRunRev(1'b0), .commRunFwd(1'b0), .commRunRev(commRunRev), .extRunFwd(extRunFwd),
    .extRunRev(1'b0), .driveOn(driveOn), .faultOutput(faultOutput), .alarmCode(alarmCode),
    .freqSel(freqSel), .inverseOn(inverseOn), .dcBrake(dcBrake), .outageFlag(outageFlag),
    .commPriority(commPriority), .dewHeat(dewHeat), .runFwd(runFwd), .runRev(runRev),
    .forcedDecel(forcedDecel), .editAll(editAll), .editOwnOnly(editOwnOnly),
    .startSearch(startSearch));

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Zero wait states expected, but the master still waits on hready
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    chk("hreadyAddr", 32'h1, 32'(hreadyout));
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    chk("hreadyData", 32'h1, 32'(hreadyout));
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr_assign(input int t, input logic [CODE_W-1:0] c);
    logic [31:0] d;
    xfer(1'b1, 32'(OFF_ASSIGN0) + 32'(4 * t), 32'(c), d);
    repeat (3) @(posedge clock);
  endtask

  task automatic wr_cfg(input logic [31:0] v);
    logic [31:0] d;
    xfer(1'b1, 32'(OFF_CONFIG), v, d);
    repeat (3) @(posedge clock);
  endtask

  // One model edge, two sync stages, one output register, then sample
  task automatic term(input int t, input logic v);
    @(posedge clock);
    termWant[t] <= v;
    repeat (5) @(posedge clock);
  endtask

  task automatic pulse_clear();
    term(1, 1'b1);
    term(1, 1'b0);
    repeat (25) @(posedge clock);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk("driveOn", 32'h1, 32'(driveOn));
    chk("commPriority", 32'h1, 32'(commPriority));
    chk("editAll", 32'h1, 32'(editAll));
    chk("freqSel", 32'(FSEL_PRIMARY), 32'(freqSel));
    xfer(1'b0, 32'(OFF_CONFIG), 32'h0, d);
    chk("config", 32'(CFG_RESET), d);
    xfer(1'b0, 32'(OFF_ASSIGN0), 32'h0, d);
    chk("assign0", 32'(ASSIGN_RESET), d);
    xfer(1'b1, 32'(OFF_STATUS), 32'hffffffff, d);
    xfer(1'b0, 32'h40, 32'h0, d);
    chk("unmapped", 32'h0, d);
    xfer(1'b0, 32'(OFF_STATUS), 32'h0, d);
    chk("statusDrive", 32'h1, 32'(d[ST_DRIVE_ON]));
    wr_assign(1, CODE_CLEAR);
  endtask

  task automatic t_trip();
    term(0, 1'b1);
    wr_assign(0, CODE_TRIP_OFF);
    chk("alarmIdle", 32'(ALARM_NONE), 32'(alarmCode));
    term(0, 1'b0);
    chk("driveOn", 32'h0, 32'(driveOn));
    chk("faultOutput", 32'h1, 32'(faultOutput));
    chk("alarmCode", 32'(ALARM_EXT_TRIP), 32'(alarmCode));
    term(0, 1'b1);
    chk("alarmLatched", 32'(ALARM_EXT_TRIP), 32'(alarmCode));
    chk("driveLatched", 32'h0, 32'(driveOn));
    term(1, 1'b1);
    chk("faultHeld", 32'h0, 32'(faultOutput));
    term(1, 1'b0);
    repeat (25) @(posedge clock);
    chk("alarmCleared", 32'(ALARM_NONE), 32'(alarmCode));
    chk("driveBack", 32'h1, 32'(driveOn));
    wr_assign(0, 11'h000);
    term(0, 1'b0);
    wr_assign(0, CODE_TRIP_ON);
    chk("tripOnIdle", 32'(ALARM_NONE), 32'(alarmCode));
    term(0, 1'b1);
    chk("tripOnFired", 32'(ALARM_EXT_TRIP), 32'(alarmCode));
    term(0, 1'b0);
    pulse_clear();
    wr_assign(0, 11'h000);
  endtask

  task automatic t_coast_freq();
    wr_assign(2, CODE_COAST);
    term(2, 1'b1);
    chk("coastDrive", 32'h0, 32'(driveOn));
    chk("coastAlarm", 32'h0, 32'({faultOutput, alarmCode}));
    term(2, 1'b0);
    chk("coastEnd", 32'h1, 32'(driveOn));
    wr_assign(2, CODE_FREQ_SW);
    chk("freqOff", 32'(FSEL_PRIMARY), 32'(freqSel));
    term(2, 1'b1);
    chk("freqOn", 32'(FSEL_SECONDARY), 32'(freqSel));
    wr_assign(3, CODE_LOCAL);
    keypadRunFwd <= 1'b1;
    term(3, 1'b1);
    chk("localFreq", 32'(FSEL_KEYPAD), 32'(freqSel));
    chk("localRun", 32'h1, 32'(runFwd));
    term(3, 1'b0);
    term(2, 1'b0);
    keypadRunFwd <= 1'b0;
    wr_assign(2, 11'h000);
    wr_assign(3, 11'h000);
  endtask

  task automatic t_inverse();
    wr_assign(2, CODE_INVERSE);
    for (int i = 0; i < 4; i++) begin
      wr_cfg((32'h1 << CFG_PRI_ANALOG) | (32'(i % 2) << CFG_REV_SENSE));
      term(2, i[1]);
      chk("inverseOn", 32'((i % 2) ^ (i / 2)), 32'(inverseOn));
    end
    wr_cfg(32'h1 << CFG_REV_SENSE);
    chk("inverseNoAnalog", 32'h0, 32'(inverseOn));
    term(2, 1'b0);
    wr_assign(2, 11'h000);
    wr_cfg(32'h0);
  endtask

  task automatic t_level(input logic [CODE_W-1:0] c, input int b);
    logic [31:0] d;
    logic [7:0] off;
    // Monitor-only levels show up in the monitor word, not in status
    off = (c == CODE_MONITOR) ? OFF_MONITOR : OFF_STATUS;
    term(4, 1'b0);
    wr_assign(4, c);
    xfer(1'b0, 32'(off), 32'h0, d);
    chk("levelOff", 32'h0, 32'(d[b]));
    term(4, 1'b1);
    xfer(1'b0, 32'(off), 32'h0, d);
    chk("levelOn", 32'h1, 32'(d[b]));
    xfer(1'b0, 32'(OFF_MONITOR), 32'h0, d);
    chk("monitorBit", 32'(c == CODE_MONITOR), 32'(d[4]));
    chk("monitorDrive", 32'h1, 32'(driveOn));
  endtask

  task automatic t_stop();
    term(0, 1'b1);
    wr_assign(0, CODE_STOP_OFF);
    term(0, 1'b0);
    chk("forcedDecel", 32'h1, 32'(forcedDecel));
    chk("stopNoAlarm", 32'(ALARM_NONE), 32'(alarmCode));
    motorHalted <= 1'b1;
    repeat (4) @(posedge clock);
    chk("stopAlarm", 32'(ALARM_FORCED_STOP), 32'(alarmCode));
    term(0, 1'b1);
    pulse_clear();
    chk("stopCleared", 32'(ALARM_NONE), 32'(alarmCode));
    wr_assign(0, 11'h000);
  endtask

  task automatic t_run();
    wr_cfg(32'h1 << CFG_RUN_SRC);
    extRunFwd <= 1'b1;
    repeat (4) @(posedge clock);
    chk("runSetting", 32'h1, 32'(runFwd));
    wr_assign(2, CODE_RUN_SW);
    wr_assign(3, CODE_FWD_ALT);
    wr_assign(4, CODE_REV_ALT);
    term(2, 1'b1);
    chk("runSwitched", 32'h0, 32'({runFwd, runRev}));
    term(3, 1'b1);
    chk("runAltFwd", 32'h2, 32'({runFwd, runRev}));
    term(3, 1'b0);
    term(4, 1'b1);
    chk("runAltRev", 32'h1, 32'({runFwd, runRev}));
    term(3, 1'b1);
    chk("runBoth", 32'h0, 32'({runFwd, runRev}));
    term(3, 1'b0);
    term(4, 1'b0);
    term(2, 1'b0);
    // Link enabled and unassigned priority: link run request wins over terminals
    commRunRev <= 1'b1;
    wr_cfg((32'h1 << CFG_RUN_SRC) | (32'h1 << CFG_COMM_EN));
    chk("runLink", 32'h1, 32'({runFwd, runRev}));
    commRunRev <= 1'b0;
    extRunFwd <= 1'b0;
    wr_cfg(32'h0);
  endtask

  task automatic t_search();
    wr_assign(4, CODE_SEARCH);
    for (int v = 1; v >= 0; v--) begin
      term(4, v[0]);
      startReq <= 1'b1;
      @(posedge clock);
      startReq <= 1'b0;
      repeat (3) @(posedge clock);
      chk("startSearch", 32'(v), 32'(startSearch));
    end
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_trip();
    t_coast_freq();
    t_inverse();
    t_level(CODE_DCBRAKE, ST_DC_BRAKE);
    chk("dcBrake", 32'h1, 32'(dcBrake));
    t_level(CODE_OUTAGE, ST_OUTAGE);
    chk("outageFlag", 32'h1, 32'(outageFlag));
    t_level(CODE_COMM, ST_COMM_PRI);
    t_level(CODE_PERMIT, ST_EDIT_ALL);
    wr_cfg(32'h1 << CFG_PROTECT);
    chk("editOwnOnly", 32'h1, 32'({editAll, editOwnOnly}));
    wr_cfg(32'h0);
    t_level(CODE_MONITOR, 4);
    t_stop();
    t_level(CODE_DEW, ST_DEW);
    chk("dewHeat", 32'h1, 32'(dewHeat));
    term(4, 1'b0);
    motorHalted <= 1'b0;
    t_run();
    t_search();
    complete_run();
  end
endmodule
